// ---- rtl/usb_bist_pkg.sv ----
/*
 * constants shared by the usb control / spare register bank and its
 * two self-test engines.
 * assumes a 50 MHz sys_clk and byte addresses on the register bus.
 */
package usb_bist_pkg;
	// ************************************************
	// register byte offsets
	// ************************************************
	localparam logic [7:0] OFF_CUSTOMER_IDENT = 8'h90;
	localparam logic [7:0] OFF_SCRATCH_ONE    = 8'h94;
	localparam logic [7:0] OFF_SCRATCH_TWO    = 8'h98;
	localparam logic [7:0] OFF_SCRATCH_THREE  = 8'h9C;
	localparam logic [7:0] OFF_USB_CTRL       = 8'hC0;
	localparam logic [7:0] OFF_IRQ_STATUS     = 8'hC4;
	localparam logic [7:0] OFF_IRQ_MASK       = 8'hC8;

	// ************************************************
	// usb control field positions
	// ************************************************
	localparam int PHY_CTRL_LSB      = 16;  // 29..16
	localparam int PHY_CTRL_W        = 14;
	localparam int PHY_EN_BIT        = 15;
	localparam int PHY_SEL_BIT       = 14;
	localparam int PHY_CUR_LSB       = 12;  // 13..12
	localparam int PHY_FAULT_BIT     = 9;
	localparam int PHY_DONE_BIT      = 8;
	localparam int FIFO_EN_BIT       = 7;
	localparam int FIFO_STAT_LSB     = 2;   // 3..2
	localparam int FIFO_FAULT_BIT    = 1;
	localparam int FIFO_DONE_BIT     = 0;

	// current field codes that aim the phy test at a port
	localparam logic [1:0] CUR_PORT1 = 2'h1;
	localparam logic [1:0] CUR_PORT2 = 2'h2;

	// ************************************************
	// reset values and interrupt layout
	// ************************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int IRQ_W = 4;  // phy done, phy fault, fifo done, fifo fault

	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_NS    = 20;
	localparam int PHY_BIST_TIME_NS = 2000;  // least run time per phy test
	localparam int PHY_BIST_CYCLES  = (PHY_BIST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// fifo test progress codes
	typedef enum logic [1:0] {
		FST_IDLE  = 2'b00,
		FST_WRITE = 2'b01,
		FST_READ  = 2'b10,
		FST_END   = 2'b11
	} fifo_state_t;
endpackage : usb_bist_pkg

// ---- rtl/phy_bist_engine.sv ----
/*
 * runs the usb phy self-test for a fixed time on the port that the
 * current field names and keeps per-port fault results.
 * assumes the phy fail flags are driven by logic on sys_clk.
 */
`timescale 1ns/1ps
module phy_bist_engine #(
	parameter int RUN_CYCLES = usb_bist_pkg::PHY_BIST_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       enable,        // test runs while high
	input  wire logic [1:0] current,       // port aim code
	input  wire logic       port_select,   // 0 reports port 1, 1 port 2
	input  wire logic       port1_fail,    // phy port 1 mismatch
	input  wire logic       port2_fail,    // phy port 2 mismatch
	output logic            port1_run,     // drive phy port 1 test
	output logic            port2_run,     // drive phy port 2 test
	output logic            done,
	output logic            fault
);
	logic [15:0] cnt_r;   // cycles left in the run
	logic        busy_r;  // run in progress
	logic        f1_r;    // port 1 fault seen
	logic        f2_r;    // port 2 fault seen

	// run timer; results held until enable drops
	always_ff @(posedge sys_clk) begin
		if (srst || !enable) begin
			cnt_r  <= 16'h0000;
			busy_r <= 1'b0;
			done   <= 1'b0;
		end else if (!busy_r && !done) begin
			busy_r <= 1'b1;
			cnt_r  <= 16'(RUN_CYCLES - 1);
		end else if (busy_r && cnt_r == 16'h0000) begin
			busy_r <= 1'b0;
			done   <= 1'b1;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	// aim the test only at the port that the current code names
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			port1_run <= 1'b0;
			port2_run <= 1'b0;
		end else begin
			port1_run <= enable && busy_r && current == usb_bist_pkg::CUR_PORT1;
			port2_run <= enable && busy_r && current == usb_bist_pkg::CUR_PORT2;
		end
	end

	// per-port fault capture while that port is under test
	always_ff @(posedge sys_clk) begin
		if (srst || !enable) begin
			f1_r <= 1'b0;
			f2_r <= 1'b0;
		end else begin
			if (port1_run && port1_fail) f1_r <= 1'b1;
			if (port2_run && port2_fail) f2_r <= 1'b1;
		end
	end

	// fault shows only once done, picked by the select bit
	assign fault = done && (port_select ? f2_r : f1_r);
endmodule : phy_bist_engine

// ---- rtl/fifo_bist_engine.sv ----
/*
 * writes a pattern through the usb fifo memory, reads it back and
 * compares. reports progress, fault and done.
 * assumes read data returns two clocks after mem_addr: one output flop
 * in the register bank, then one clock of memory read latency.
 */
`timescale 1ns/1ps
module fifo_bist_engine #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 8
) (
	input  wire logic                     sys_clk,
	input  wire logic                     srst,
	input  wire logic                     enable,
	output logic [$clog2(DEPTH)-1:0]      mem_addr,
	output logic [WIDTH-1:0]              mem_wdata,
	output logic                          mem_we,
	input  wire logic [WIDTH-1:0]         mem_rdata,
	output usb_bist_pkg::fifo_state_t     status,
	output logic                          fault,
	output logic                          done
);
	localparam int AW = $clog2(DEPTH);
	logic          chk_r;   // read address at the memory this cycle
	logic [AW-1:0] chk_a_r; // address of that data
	logic          chk2_r;   // read data due at the compare stage
	logic [AW-1:0] chk2_a_r; // address of that data

	// pattern depends on address so stuck address lines show up
	function automatic logic [WIDTH-1:0] pat(input logic [AW-1:0] a);
		pat = WIDTH'({a, ~a, a, ~a});
	endfunction : pat

	// sequencer: write all, read all, hold the end state
	always_ff @(posedge sys_clk) begin
		if (srst || !enable) begin
			status   <= usb_bist_pkg::FST_IDLE;
			mem_addr <= '0;
			mem_we   <= 1'b0;
			done     <= 1'b0;
		end else begin
			case (status)
				usb_bist_pkg::FST_IDLE: begin
					status <= usb_bist_pkg::FST_WRITE;
					mem_we <= 1'b1;
				end
				usb_bist_pkg::FST_WRITE: begin
					if (mem_addr == AW'(DEPTH - 1)) begin
						mem_we   <= 1'b0;
						mem_addr <= '0;
						status   <= usb_bist_pkg::FST_READ;
					end else begin
						mem_addr <= mem_addr + 1'b1;
					end
				end
				usb_bist_pkg::FST_READ: begin
					if (mem_addr == AW'(DEPTH - 1)) status <= usb_bist_pkg::FST_END;
					else mem_addr <= mem_addr + 1'b1;
				end
				default: begin
					if (!chk_r && !chk2_r) done <= 1'b1;
				end
			endcase
		end
	end

	assign mem_wdata = pat(mem_addr);

	// two-stage compare pipeline matches the round trip through the
	// bank's output flop and the memory's read latency
	always_ff @(posedge sys_clk) begin
		if (srst || !enable) begin
			chk_r    <= 1'b0;
			chk_a_r  <= '0;
			chk2_r   <= 1'b0;
			chk2_a_r <= '0;
			fault    <= 1'b0;
		end else begin
			chk_r    <= status == usb_bist_pkg::FST_READ;
			chk_a_r  <= mem_addr;
			chk2_r   <= chk_r;
			chk2_a_r <= chk_a_r;
			if (chk2_r && mem_rdata != pat(chk2_a_r)) fault <= 1'b1;
		end
	end
endmodule : fifo_bist_engine

// ---- rtl/usb_bist_regs.sv ----
/*
 * register bank: customer ident, three scratch words, the usb control
 * register with its phy and fifo self-tests, and an interrupt pair.
 * assumes an avalon-mm master with byte addresses and sys_clk at 50 MHz.
 */
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps

module usb_bist_regs #(
	parameter logic [31:0] CUSTOMER_IDENT = 32'h5A5A_0001, // arbitrary value
	parameter int          PHY_CYCLES     = usb_bist_pkg::PHY_BIST_CYCLES,
	parameter int          FIFO_DEPTH     = 16,
	parameter int          FIFO_WIDTH     = 8
) (
	input  wire logic                          sys_clk,
	input  wire logic                          srst,
	// avalon-mm slave
	input  wire logic [7:0]                    address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [31:0]                   writedata,
	input  wire logic [3:0]                    byteenable,
	output logic [31:0]                        readdata,
	output logic                               waitrequest,
	output logic                               irq,
	// phy side
	output logic [13:0]                        phy_ctrl_field,
	output logic                               phy_port1_run,
	output logic                               phy_port2_run,
	input  wire logic                          phy_port1_fail,
	input  wire logic                          phy_port2_fail,
	// fifo memory side
	output logic [$clog2(FIFO_DEPTH)-1:0]      fifo_mem_addr,
	output logic [FIFO_WIDTH-1:0]              fifo_mem_wdata,
	output logic                               fifo_mem_we,
	input  wire logic [FIFO_WIDTH-1:0]         fifo_mem_rdata
);
	// ************************************************
	// storage
	// ************************************************
	logic [31:0] scratch_r [3];        // scratch words
	logic [31:0] ctrl_r;               // writable bits of usb control
	logic [3:0]  irq_stat_r;           // sticky events
	logic [3:0]  irq_mask_r;           // 1 lets an event through
	logic [31:0] rd_nxt;               // read mux
	logic [31:0] wmask;                // byte lanes as bit mask
	logic        wr_go;                // write commits this edge
	logic        phy_done;
	logic        phy_fault;
	logic        fifo_done;
	logic        fifo_fault;
	logic [3:0]  evt_now;              // event levels
	logic [3:0]  evt_d_r;              // last cycle's levels
	logic [3:0]  evt_rise;
	usb_bist_pkg::fifo_state_t fifo_stat;
	logic [FIFO_WIDTH-1:0]     fifo_wd;
	logic [$clog2(FIFO_DEPTH)-1:0] fifo_a;
	logic                      fifo_w;
	logic                      p1_run;
	logic                      p2_run;

	// only the writable fields of usb control can be stored
	localparam logic [31:0] CTRL_WMASK = 32'h3FFF_F080;

	// ************************************************
	// bus slave
	// ************************************************
	// one wait cycle per access: waitrequest drops the cycle after a
	// request is seen, and that edge completes it
	always_ff @(posedge sys_clk) begin
		if (srst) waitrequest <= 1'b1;
		else waitrequest <= !((read || write) && waitrequest);
	end

	assign wr_go = write && !waitrequest;
	assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
	                {8{byteenable[1]}}, {8{byteenable[0]}}};

	// read data loaded together with the waitrequest drop
	always_ff @(posedge sys_clk) begin
		if (srst) readdata <= usb_bist_pkg::RST_WORD;
		else if (read && waitrequest) readdata <= rd_nxt;
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (address)
			usb_bist_pkg::OFF_CUSTOMER_IDENT: rd_nxt = CUSTOMER_IDENT;
			usb_bist_pkg::OFF_SCRATCH_ONE:    rd_nxt = scratch_r[0];
			usb_bist_pkg::OFF_SCRATCH_TWO:    rd_nxt = scratch_r[1];
			usb_bist_pkg::OFF_SCRATCH_THREE:  rd_nxt = scratch_r[2];
			usb_bist_pkg::OFF_USB_CTRL: begin
				rd_nxt = ctrl_r & CTRL_WMASK;
				rd_nxt[usb_bist_pkg::PHY_FAULT_BIT]  = phy_fault;
				rd_nxt[usb_bist_pkg::PHY_DONE_BIT]   = phy_done;
				rd_nxt[usb_bist_pkg::FIFO_STAT_LSB +: 2] = fifo_stat;
				rd_nxt[usb_bist_pkg::FIFO_FAULT_BIT] = fifo_fault;
				rd_nxt[usb_bist_pkg::FIFO_DONE_BIT]  = fifo_done;
			end
			usb_bist_pkg::OFF_IRQ_STATUS: rd_nxt = {28'h000_0000, irq_stat_r};
			usb_bist_pkg::OFF_IRQ_MASK:   rd_nxt = {28'h000_0000, irq_mask_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// ************************************************
	// scratch words
	// ************************************************
	// one loop entry per word; no side effects
	for (genvar g = 0; g < 3; g++) begin : g_scr
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				scratch_r[g] <= usb_bist_pkg::RST_WORD;
			end else if (wr_go && address == usb_bist_pkg::OFF_SCRATCH_ONE + 8'(4 * g)) begin
				scratch_r[g] <= (scratch_r[g] & ~wmask) | (writedata & wmask);
			end
		end
	end

	// ************************************************
	// usb control
	// ************************************************
	// status bits are never stored, so writes to them have no effect
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_r <= usb_bist_pkg::RST_WORD;
		end else if (wr_go && address == usb_bist_pkg::OFF_USB_CTRL) begin
			ctrl_r <= (ctrl_r & ~(wmask & CTRL_WMASK))
			        | (writedata & wmask & CTRL_WMASK);
		end
	end

	// phy control field leaves through its own flop stage
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phy_ctrl_field <= 14'h0000;
		end else begin
			phy_ctrl_field <= ctrl_r[usb_bist_pkg::PHY_CTRL_LSB +: 14];
		end
	end

	// ************************************************
	// self-test engines
	// ************************************************
	phy_bist_engine #(
		.RUN_CYCLES (PHY_CYCLES)
	) u_phy (
		.sys_clk     (sys_clk),
		.srst        (srst),
		.enable      (ctrl_r[usb_bist_pkg::PHY_EN_BIT]),
		.current     (ctrl_r[usb_bist_pkg::PHY_CUR_LSB +: 2]),
		.port_select (ctrl_r[usb_bist_pkg::PHY_SEL_BIT]),
		.port1_fail  (phy_port1_fail),
		.port2_fail  (phy_port2_fail),
		.port1_run   (p1_run),
		.port2_run   (p2_run),
		.done        (phy_done),
		.fault       (phy_fault)
	);

	fifo_bist_engine #(
		.DEPTH (FIFO_DEPTH),
		.WIDTH (FIFO_WIDTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.enable    (ctrl_r[usb_bist_pkg::FIFO_EN_BIT]),
		.mem_addr  (fifo_a),
		.mem_wdata (fifo_wd),
		.mem_we    (fifo_w),
		.mem_rdata (fifo_mem_rdata),
		.status    (fifo_stat),
		.fault     (fifo_fault),
		.done      (fifo_done)
	);

	// engine outputs leave through flops; this flop plus the memory's
	// own clock puts read data two cycles after the engine's address,
	// which the engine's two-stage compare allows for
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phy_port1_run  <= 1'b0;
			phy_port2_run  <= 1'b0;
			fifo_mem_addr  <= '0;
			fifo_mem_wdata <= '0;
			fifo_mem_we    <= 1'b0;
		end else begin
			phy_port1_run  <= p1_run;
			phy_port2_run  <= p2_run;
			fifo_mem_addr  <= fifo_a;
			fifo_mem_wdata <= fifo_wd;
			fifo_mem_we    <= fifo_w;
		end
	end

	// ************************************************
	// interrupts
	// ************************************************
	assign evt_now  = {fifo_fault, fifo_done, phy_fault, phy_done};
	assign evt_rise = evt_now & ~evt_d_r;

	// edge detect on done and fault levels
	always_ff @(posedge sys_clk) begin
		if (srst) evt_d_r <= 4'h0;
		else evt_d_r <= evt_now;
	end

	// sticky status: write one clears, a new event in the same cycle wins
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_stat_r <= 4'h0;
		end else if (wr_go && address == usb_bist_pkg::OFF_IRQ_STATUS && byteenable[0]) begin
			irq_stat_r <= (irq_stat_r & ~writedata[3:0]) | evt_rise;
		end else begin
			irq_stat_r <= irq_stat_r | evt_rise;
		end
	end

	// mask register, plain read/write
	always_ff @(posedge sys_clk) begin
		if (srst) irq_mask_r <= 4'h0;
		else if (wr_go && address == usb_bist_pkg::OFF_IRQ_MASK && byteenable[0])
			irq_mask_r <= writedata[3:0];
	end

	// level interrupt, registered
	always_ff @(posedge sys_clk) begin
		if (srst) irq <= 1'b0;
		else irq <= |((irq_stat_r | evt_rise) & irq_mask_r);
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	AST_IDENT_READ: assert property (
		read && waitrequest && address == usb_bist_pkg::OFF_CUSTOMER_IDENT
		|=> readdata == CUSTOMER_IDENT)
		else $error("customer ident read wrong");
	AST_SCRATCH_HOLD: assert property (
		wr_go && address == usb_bist_pkg::OFF_SCRATCH_ONE && byteenable == 4'hF
		|=> scratch_r[0] == $past(writedata))
		else $error("scratch word not stored");
	AST_PHY_CTRL_OUT: assert property (
		##1 phy_ctrl_field == $past(ctrl_r[29:16]))
		else $error("phy control field not driven");
	AST_PHY_PORT_AIM: assert property (
		phy_port1_run |-> !phy_port2_run)
		else $error("both phy ports under test");
	AST_PHY_DONE_TIME: assert property (
		$rose(ctrl_r[15]) |-> !phy_done [*2])
		else $error("phy done too early");
	AST_PHY_FAULT_GATED: assert property (
		phy_fault |-> phy_done && (ctrl_r[15] || $past(ctrl_r[15])))
		else $error("phy fault without done");
	AST_DONE_STICKY: assert property (
		phy_done && ctrl_r[15] |=> phy_done)
		else $error("phy done dropped while enabled");
	AST_FIFO_CLEAR: assert property (
		!ctrl_r[7] |=> !fifo_done && !fifo_fault && fifo_stat == usb_bist_pkg::FST_IDLE)
		else $error("fifo results not cleared");
	AST_FIFO_DONE_STATE: assert property (
		fifo_done |-> fifo_stat == usb_bist_pkg::FST_END)
		else $error("fifo done before end");
	AST_RSVD_ZERO: assert property (
		read && waitrequest && address == usb_bist_pkg::OFF_USB_CTRL
		|=> readdata[31:30] == 2'h0 && readdata[11:10] == 2'h0 && readdata[6:4] == 3'h0)
		else $error("reserved bits not zero");
	AST_WAIT_ONE: assert property (
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest timing wrong");

	// interrupt level and sticky status, fifo results held while enabled
	AST_IRQ_LEVEL: assert property (
		|(irq_stat_r & irq_mask_r) |=> irq)
		else $error("irq low with unmasked status set");
	AST_STATUS_STICKY: assert property (
		irq_stat_r[0] && !(wr_go && address == usb_bist_pkg::OFF_IRQ_STATUS)
		|=> irq_stat_r[0])
		else $error("status bit lost without clear");
	AST_FIFO_FAULT_HOLD: assert property (
		fifo_fault && ctrl_r[7] |=> fifo_fault)
		else $error("fifo fault dropped while enabled");
	AST_FIFO_DONE_HOLD: assert property (
		fifo_done && ctrl_r[7] |=> fifo_done)
		else $error("fifo done dropped while enabled");

	COV_PHY_DONE:   cover property ($rose(phy_done));
	COV_PHY_FAULT:  cover property ($rose(phy_fault));
	COV_FIFO_DONE:  cover property ($rose(fifo_done));
	COV_IRQ:        cover property ($rose(irq));
	COV_FIFO_FAULT: cover property ($rose(fifo_fault));
endmodule : usb_bist_regs

// ---- testbench/usb_bist_regs_bench.sv ----
/*
 * self-checking bench for usb_bist_regs: avalon-mm tasks, phy fail drive,
 * behavioural fifo memory with one-cycle read latency and fault injection.
 * assumes the design package and modules are compiled before this file.
 */
`timescale 1ns/1ps
module usb_bist_regs_bench;
	// ************************************************
	// parameters and pins
	// ************************************************
	localparam int          DEPTH = 4;              // short fifo keeps runs brief
	localparam logic [31:0] IDENT = 32'h1234_ABCD;  // arbitrary value
	logic        sys_clk = 1'b0;
	logic        srst    = 1'b1;
	logic [7:0]  address = 8'h00;
	logic        read    = 1'b0;
	logic        write   = 1'b0;
	logic [31:0] writedata  = 32'h0000_0000;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        irq;
	logic [13:0] phy_ctrl_field;
	logic        phy_port1_run;
	logic        phy_port2_run;
	logic        phy_port1_fail = 1'b0;
	logic        phy_port2_fail = 1'b0;
	logic [1:0]  fifo_mem_addr;
	logic [7:0]  fifo_mem_wdata;
	logic        fifo_mem_we;
	logic [7:0]  fifo_mem_rdata = 8'h00;
	logic [7:0]  mem [DEPTH];             // fifo memory model
	logic        corrupt = 1'b0;          // flips bit 0 of read data
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles     = 0;

	always #10 sys_clk = ~sys_clk;        // 50 MHz

	usb_bist_regs #(.CUSTOMER_IDENT(IDENT), .PHY_CYCLES(4), .FIFO_DEPTH(DEPTH),
		.FIFO_WIDTH(8)) uut (.sys_clk(sys_clk), .srst(srst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.phy_ctrl_field(phy_ctrl_field), .phy_port1_run(phy_port1_run),
		.phy_port2_run(phy_port2_run), .phy_port1_fail(phy_port1_fail),
		.phy_port2_fail(phy_port2_fail), .fifo_mem_addr(fifo_mem_addr),
		.fifo_mem_wdata(fifo_mem_wdata), .fifo_mem_we(fifo_mem_we),
		.fifo_mem_rdata(fifo_mem_rdata));

	// memory: write at the strobe edge, data for last cycle's address
	always @(posedge sys_clk) begin
		if (fifo_mem_we) begin
			mem[fifo_mem_addr] <= fifo_mem_wdata;
		end
		fifo_mem_rdata <= mem[fifo_mem_addr] ^ {7'h00, corrupt};
	end

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			$display("CHECK FAILED at %0t: timeout", $time);
			finish_test();
		end
	end

	// ************************************************
	// compare, report and bus tasks
	// ************************************************
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask : check_bit

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	// request held until waitrequest is sampled low
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be);
		@(posedge sys_clk);
		address    <= a;
		writedata  <= d;
		byteenable <= be;
		write      <= 1'b1;
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		address <= a;
		read    <= 1'b1;
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask : bus_read

	// expected usb control word from its fields
	function automatic logic [31:0] ctrl_word(input logic [13:0] pc, input logic en,
			input logic sel, input logic [1:0] cur, input logic flt, input logic dn,
			input logic [7:0] low);
		return {2'b00, pc, en, sel, cur, 2'b00, flt, dn, low};
	endfunction : ctrl_word

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		logic [7:0]  offs [8];
		logic [31:0] rd;
		logic [31:0] v;
		logic [13:0] pc;
		logic [1:0]  cur;
		logic        sel;
		logic        f1;
		logic        f2;
		logic        flt;
		offs = '{8'h90, 8'h94, 8'h98, 8'h9C, 8'hC0, 8'hC4, 8'hC8, 8'hA0};
		void'($urandom(32'h367e0731));
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		// reset values, unmapped offset reads zero
		foreach (offs[i]) begin
			bus_read(offs[i], rd);
			check_word(rd, (i == 0) ? IDENT : 32'h0000_0000, "reset value");
		end
		bus_write(usb_bist_pkg::OFF_CUSTOMER_IDENT, $urandom, 4'hF);
		bus_read(usb_bist_pkg::OFF_CUSTOMER_IDENT, rd);
		check_word(rd, IDENT, "ident after write");
		$display("test reset_and_ident done");
		// three scratch words are independent, byte lanes honoured
		v = $urandom;
		bus_write(usb_bist_pkg::OFF_SCRATCH_ONE, v, 4'hF);
		bus_write(usb_bist_pkg::OFF_SCRATCH_TWO, ~v, 4'hF);
		bus_write(usb_bist_pkg::OFF_SCRATCH_THREE, 32'hFFFF_FFFF, 4'b0101);
		bus_read(usb_bist_pkg::OFF_SCRATCH_ONE, rd);
		check_word(rd, v, "scratch one");
		bus_read(usb_bist_pkg::OFF_SCRATCH_TWO, rd);
		check_word(rd, ~v, "scratch two");
		bus_read(usb_bist_pkg::OFF_SCRATCH_THREE, rd);
		check_word(rd, 32'h00FF_00FF, "scratch three lanes");
		$display("test scratch done");
		// all ones with both enables clear: reserved and status bits stay zero
		bus_write(usb_bist_pkg::OFF_USB_CTRL, 32'hFFFF_7F7F, 4'hF);
		bus_read(usb_bist_pkg::OFF_USB_CTRL, rd);
		check_word(rd, ctrl_word(14'h3FFF, 0, 1, 2'b11, 0, 0, 8'h00), "ctrl ones");
		check_word({18'h0_0000, phy_ctrl_field}, 32'h0000_3FFF, "phy ctrl out");
		$display("test reserved done");
		// phy test over every current code, both report ports, random fails
		bus_write(usb_bist_pkg::OFF_IRQ_MASK, 32'h0000_0001, 4'h1);
		for (int i = 0; i < 8; i++) begin
			cur = i[1:0];
			sel = i[2];
			pc  = 14'($urandom);
			f1  = 1'($urandom);
			f2  = 1'($urandom);
			flt = sel ? (cur == usb_bist_pkg::CUR_PORT2 && f2)
				: (cur == usb_bist_pkg::CUR_PORT1 && f1);
			phy_port1_fail <= f1;
			phy_port2_fail <= f2;
			bus_write(usb_bist_pkg::OFF_IRQ_STATUS, 32'h0000_000F, 4'h1);
			bus_write(usb_bist_pkg::OFF_USB_CTRL, ctrl_word(pc, 1, sel, cur, 0, 0, 0), 4'hF);
			// run outputs rise three edges after the enable lands; look one later
			repeat (4) @(posedge sys_clk);
			check_bit(phy_port1_run, cur == 2'b01, "port1 run");
			check_bit(phy_port2_run, cur == 2'b10, "port2 run");
			check_word({18'h0_0000, phy_ctrl_field}, {18'h0_0000, pc}, "phy ctrl");
			rd = 32'h0000_0000;
			for (int k = 0; k < 20 && rd[8] !== 1'b1; k++) begin
				bus_read(usb_bist_pkg::OFF_USB_CTRL, rd);
			end
			check_word(rd, ctrl_word(pc, 1, sel, cur, flt, 1, 0), "phy done");
			repeat (3) @(posedge sys_clk);
			check_bit(irq, 1'b1, "irq phy done");
			bus_read(usb_bist_pkg::OFF_USB_CTRL, rd);
			check_word(rd, ctrl_word(pc, 1, sel, cur, flt, 1, 0), "phy held");
			bus_write(usb_bist_pkg::OFF_USB_CTRL, ctrl_word(pc, 0, sel, cur, 0, 0, 0), 4'hF);
			bus_read(usb_bist_pkg::OFF_USB_CTRL, rd);
			check_word(rd, ctrl_word(pc, 0, sel, cur, 0, 0, 0), "phy cleared");
		end
		$display("test phy done");
		// fifo test good then corrupted; mask on, clear, then mask off
		bus_write(usb_bist_pkg::OFF_IRQ_STATUS, 32'h0000_000F, 4'h1);
		bus_write(usb_bist_pkg::OFF_IRQ_MASK, 32'h0000_0004, 4'h1);
		for (int j = 0; j < 2; j++) begin
			corrupt <= j[0];
			bus_write(usb_bist_pkg::OFF_USB_CTRL, 32'h0000_0080, 4'hF);
			rd = 32'h0000_0000;
			for (int k = 0; k < 40 && rd[0] !== 1'b1; k++) begin
				bus_read(usb_bist_pkg::OFF_USB_CTRL, rd);
			end
			check_word(rd, {24'h00_0000, 6'b1000_11, j[0], 1'b1}, "fifo done");
			repeat (3) @(posedge sys_clk);
			check_bit(irq, j == 0, "irq fifo done");
			bus_read(usb_bist_pkg::OFF_IRQ_STATUS, rd);
			check_word(rd, j ? 32'h0000_000C : 32'h0000_0004, "irq status");
			bus_write(usb_bist_pkg::OFF_IRQ_STATUS, 32'h0000_0004, 4'h1);
			bus_write(usb_bist_pkg::OFF_IRQ_MASK, 32'h0000_0000, 4'h1);
			repeat (3) @(posedge sys_clk);
			check_bit(irq, 1'b0, "irq cleared");
			bus_write(usb_bist_pkg::OFF_USB_CTRL, 32'h0000_0000, 4'hF);
			bus_read(usb_bist_pkg::OFF_USB_CTRL, rd);
			check_word(rd, 32'h0000_0000, "fifo cleared");
		end
		$display("test fifo done");
		finish_test();
	end
endmodule : usb_bist_regs_bench
